//--- hdl/rxpm_map.svh
// Register map, field layout, reset values and byte counter limit of the pattern matcher
`ifndef RXPM_MAP_SVH
`define RXPM_MAP_SVH

// Register indices; byte address is four times the index
`define RXPM_IDX_PAT_50_51 12'h4c1
`define RXPM_IDX_PAT_52_53 12'h4c2
`define RXPM_IDX_PAT_54_55 12'h4c3
`define RXPM_IDX_PAT_56_57 12'h4c4
`define RXPM_IDX_PAT_58_59 12'h4c5
`define RXPM_IDX_PAT_60_61 12'h4c6
`define RXPM_IDX_PAT_62_63 12'h4c7
`define RXPM_IDX_MASK_0_15 12'h4c8
`define RXPM_IDX_MASK_16_31 12'h4c9
`define RXPM_IDX_MASK_32_47 12'h4ca
`define RXPM_IDX_MASK_48_63 12'h4cb
`define RXPM_IDX_START_CTRL 12'h4cc

// Counts of registers and pattern geometry
`define RXPM_NUM_PAT_REGS 7
`define RXPM_NUM_MASK_REGS 4
`define RXPM_NUM_LOW_BYTES 50
`define RXPM_PAT_BYTES 64

// Field positions
`define RXPM_EVEN_BYTE_LSB 0
`define RXPM_ODD_BYTE_LSB 8
`define RXPM_START_MSB 5

// Reset values
`define RXPM_PAT_RESET 16'h0000
`define RXPM_MASK_RESET 16'h0000
`define RXPM_START_RESET 6'h0c

// Byte counter saturation after the delimiter
`define RXPM_CNT_MAX 8'hff

`endif

//--- hdl/rxpm_pkg.sv
// Types shared by the pattern matcher configuration and compare logic
package rxpm_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } rxpm_apb_req_t;

  typedef struct packed {
    logic [6:0][15:0] pat;
    logic [3:0][15:0] mask;
    logic [5:0] start;
    logic [31:0] rdata;
    logic slverr;
  } rxpm_regs_t;

  typedef enum logic {
    RXPM_IDLE,
    RXPM_COMP
  } rxpm_state_t;

  typedef struct packed {
    rxpm_state_t state;
    logic [7:0] cnt;
    logic miss;
    logic match;
    logic match_valid;
  } rxpm_cmp_t;

endpackage

//--- hdl/rxpm_matcher.sv
// Frame comparator against the configured 64-byte pattern and byte masks
`timescale 1ns/1ps
`include "rxpm_map.svh"
module rxpm_matcher
  import rxpm_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [63:0][7:0] i_pattern,
  input wire logic [63:0] i_mask,
  input wire logic [5:0] i_start,
  input wire logic i_rx_sfd,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_end,
  output logic o_match,
  output logic o_match_valid
);

  rxpm_cmp_t r;
  rxpm_cmp_t next_r;
  logic [63:0] unseen_unmasked;
  logic [7:0] seen;
  logic [7:0] cnt_adv;

  // Positions not yet received that are still compared
  generate
    for (genvar g = 0; g < `RXPM_PAT_BYTES; g++) begin : g_unseen
      assign unseen_unmasked[g] = !i_mask[g] && (8'(g) >= seen);
    end
  endgenerate

  // Kept apart from the state logic so the window check has no loop
  always_comb begin
    cnt_adv = r.cnt;
    if (r.state == RXPM_COMP && i_rx_valid && r.cnt != `RXPM_CNT_MAX) begin
      cnt_adv = r.cnt + 8'h01;
    end
    seen = 8'h00;
    if (cnt_adv > {2'b00, i_start}) begin
      seen = cnt_adv - {2'b00, i_start};
    end
  end

  always_comb begin
    logic miss_now;
    logic [7:0] pos;
    miss_now = r.miss;
    pos = 8'h00;
    next_r = r;
    next_r.match_valid = 1'b0;
    case (r.state)
      RXPM_IDLE: begin
        if (i_rx_sfd) begin
          next_r.state = RXPM_COMP;
          next_r.cnt = 8'h00;
          next_r.miss = 1'b0;
        end
      end
      RXPM_COMP: begin
        if (i_rx_valid) begin
          pos = r.cnt - {2'b00, i_start};
          // Compare window opens start bytes after the delimiter
          if (r.cnt >= {2'b00, i_start} && pos < 8'(`RXPM_PAT_BYTES)) begin
            if (!i_mask[pos[5:0]] && i_rx_data != i_pattern[pos[5:0]]) begin
              miss_now = 1'b1;
            end
          end
        end
        next_r.cnt = cnt_adv;
        next_r.miss = miss_now;
        if (i_rx_end) begin
          // Short frames fail unless the missing bytes are masked
          next_r.match = !miss_now && (unseen_unmasked == 64'h0);
          next_r.match_valid = 1'b1;
          next_r.state = RXPM_IDLE;
        end else if (i_rx_sfd) begin
          next_r.cnt = 8'h00;
          next_r.miss = 1'b0;
        end
      end
      default: begin
        next_r.state = RXPM_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      r <= '{state: RXPM_IDLE, cnt: 8'h00, miss: 1'b0, match: 1'b0,
             match_valid: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign o_match = r.match;
  assign o_match_valid = r.match_valid;

endmodule // rxpm_matcher

//--- hdl/rxpm_config_regs.sv
// APB register bank for pattern bytes 50-63, byte masks and start point
`timescale 1ns/1ps
`include "rxpm_map.svh"
module rxpm_config_regs
  import rxpm_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire rxpm_apb_req_t i_apb,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic [49:0][7:0] i_pattern_low,
  input wire logic i_rx_sfd,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_end,
  output logic [13:0][7:0] o_pattern_high,
  output logic [63:0] o_mask,
  output logic [5:0] o_start_offset,
  output logic o_match,
  output logic o_match_valid
);

  rxpm_regs_t r;
  rxpm_regs_t next_r;

  logic [11:0] idx;
  logic aligned;
  logic setup;
  logic wr_acc;
  logic [`RXPM_NUM_PAT_REGS-1:0] pat_hit;
  logic [`RXPM_NUM_MASK_REGS-1:0] mask_hit;
  logic start_hit;
  logic [15:0] lane_mask;
  logic [63:0][7:0] pattern_all;

  assign idx = i_apb.paddr[13:2];
  // Upper address bits and sub-word offsets never decode
  assign aligned = (i_apb.paddr[1:0] == 2'b00) && (i_apb.paddr[15:14] == 2'b00);
  assign setup = i_apb.psel && !i_apb.penable;
  assign wr_acc = i_apb.psel && i_apb.penable && i_apb.pwrite && !r.slverr;
  assign lane_mask = {{8{i_apb.pstrb[1]}}, {8{i_apb.pstrb[0]}}};

  // Register decode, one hit line per entry
  generate
    for (genvar g = 0; g < `RXPM_NUM_PAT_REGS; g++) begin : g_pat_hit
      assign pat_hit[g] = aligned &&
        (idx == `RXPM_IDX_PAT_50_51 + 12'(g));
    end
    for (genvar g = 0; g < `RXPM_NUM_MASK_REGS; g++) begin : g_mask_hit
      assign mask_hit[g] = aligned &&
        (idx == `RXPM_IDX_MASK_0_15 + 12'(g));
    end
  endgenerate
  assign start_hit = aligned && (idx == `RXPM_IDX_START_CTRL);

  always_comb begin
    logic [31:0] rd;
    logic hit;
    rd = 32'h0000_0000;
    hit = 1'b0;
    next_r = r;
    for (int i = 0; i < `RXPM_NUM_PAT_REGS; i++) begin
      if (pat_hit[i]) begin
        rd = {16'h0000, r.pat[i]};
        hit = 1'b1;
      end
    end
    for (int i = 0; i < `RXPM_NUM_MASK_REGS; i++) begin
      if (mask_hit[i]) begin
        rd = {16'h0000, r.mask[i]};
        hit = 1'b1;
      end
    end
    if (start_hit) begin
      // Bits above the start point read as zero
      rd = {26'h0, r.start};
      hit = 1'b1;
    end
    // Read data and error captured in setup, so access is zero-wait
    if (setup) begin
      next_r.rdata = i_apb.pwrite ? 32'h0000_0000 : rd;
      next_r.slverr = !hit;
    end
    if (wr_acc) begin
      for (int i = 0; i < `RXPM_NUM_PAT_REGS; i++) begin
        if (pat_hit[i]) begin
          next_r.pat[i] = (r.pat[i] & ~lane_mask) |
                          (i_apb.pwdata[15:0] & lane_mask);
        end
      end
      for (int i = 0; i < `RXPM_NUM_MASK_REGS; i++) begin
        if (mask_hit[i]) begin
          next_r.mask[i] = (r.mask[i] & ~lane_mask) |
                           (i_apb.pwdata[15:0] & lane_mask);
        end
      end
      if (start_hit && i_apb.pstrb[0]) begin
        next_r.start = i_apb.pwdata[`RXPM_START_MSB:0];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      r.pat <= {`RXPM_NUM_PAT_REGS{`RXPM_PAT_RESET}};
      r.mask <= {`RXPM_NUM_MASK_REGS{`RXPM_MASK_RESET}};
      r.start <= `RXPM_START_RESET;
      r.rdata <= 32'h0000_0000;
      r.slverr <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign o_pready = 1'b1;
  assign o_prdata = r.rdata;
  assign o_pslverr = r.slverr && i_apb.psel && i_apb.penable;

  // Even byte in the low half, odd byte in the high half
  generate
    for (genvar g = 0; g < `RXPM_NUM_PAT_REGS; g++) begin : g_pat_out
      assign o_pattern_high[2*g] =
        r.pat[g][`RXPM_EVEN_BYTE_LSB +: 8];
      assign o_pattern_high[2*g+1] =
        r.pat[g][`RXPM_ODD_BYTE_LSB +: 8];
    end
  endgenerate

  assign o_mask = r.mask;
  assign o_start_offset = r.start;
  assign pattern_all = {o_pattern_high, i_pattern_low};

  // Live config is used; rewriting it mid-frame affects that frame
  rxpm_matcher i_rxpm_matcher (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_pattern(pattern_all),
    .i_mask(r.mask),
    .i_start(r.start),
    .i_rx_sfd(i_rx_sfd),
    .i_rx_valid(i_rx_valid),
    .i_rx_data(i_rx_data),
    .i_rx_end(i_rx_end),
    .o_match(o_match),
    .o_match_valid(o_match_valid)
  );

endmodule // rxpm_config_regs

//--- verif/rxpm_config_regs_asserts.sv
// Property checks on the pattern matcher register bank ports
`timescale 1ns/1ps
module rxpm_config_regs_chk
  import rxpm_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire rxpm_apb_req_t i_apb,
  input wire logic [31:0] o_prdata,
  input wire logic [13:0][7:0] o_pattern_high,
  input wire logic [63:0] o_mask,
  input wire logic [5:0] o_start_offset,
  input wire logic i_rx_end,
  input wire logic o_match,
  input wire logic o_match_valid
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire logic acc = i_apb.psel && i_apb.penable;
  wire logic wr = acc && i_apb.pwrite && i_apb.pstrb == 4'hf;
  a_pat_write: assert property (
    wr && i_apb.paddr == 16'h1308
    |=> o_pattern_high[3:2] == $past(i_apb.pwdata[15:0]))
    else $error("pattern write lost");
  a_mask_write: assert property (
    wr && i_apb.paddr == 16'h1320
    |=> o_mask[15:0] == $past(i_apb.pwdata[15:0]))
    else $error("mask write lost");
  a_pat_read: assert property (
    acc && !i_apb.pwrite && i_apb.paddr == 16'h130c
    |-> o_prdata == {16'h0, o_pattern_high[5:4]})
    else $error("pattern read wrong");
  a_pat_reset: assert property ($past(i_rst) |-> o_pattern_high == '0)
    else $error("pattern not cleared");
  a_mask_reset: assert property ($past(i_rst) |-> o_mask == '0)
    else $error("mask not cleared");
  a_start_reset: assert property ($past(i_rst) |-> o_start_offset == 6'h0c)
    else $error("start offset default wrong");
  a_result_cause: assert property (o_match_valid |-> $past(i_rx_end))
    else $error("result without frame end");
  a_result_hold: assert property (!o_match_valid |-> $stable(o_match))
    else $error("match changed without result");
endmodule // rxpm_config_regs_chk

bind rxpm_config_regs rxpm_config_regs_chk i_rxpm_config_regs_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_apb(i_apb),
  .o_prdata(o_prdata), .o_pattern_high(o_pattern_high), .o_mask(o_mask),
  .o_start_offset(o_start_offset), .i_rx_end(i_rx_end),
  .o_match(o_match), .o_match_valid(o_match_valid)
);

//--- verif/rxpm_config_regs_test.sv
// Self-checking bench for the pattern matcher register bank
`timescale 1ns/1ps
module rxpm_config_regs_test import rxpm_pkg::*;;
  logic clk = 0;
  logic rst = 1;
  rxpm_apb_req_t apb = '0;
  logic sfd = 0, vld = 0, fend = 0;
  logic [7:0] dat = 0;
  logic [49:0][7:0] plow = '0;
  logic pready, pslverr, match, mvalid, e, m;
  logic [31:0] prdata, r, d;
  logic [13:0][7:0] phigh;
  logic [63:0] mask;
  logic [5:0] start;
  logic [15:0] mk;
  logic [3:0] strb = 4'hf;
  int fail_count = 0, checks = 0, b;

  rxpm_config_regs i_rxpm_config_regs (
    .i_ref_clk(clk), .i_rst(rst), .i_apb(apb), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(pslverr), .i_pattern_low(plow),
    .i_rx_sfd(sfd), .i_rx_valid(vld), .i_rx_data(dat), .i_rx_end(fend),
    .o_pattern_high(phigh), .o_mask(mask), .o_start_offset(start),
    .o_match(match), .o_match_valid(mvalid));

  initial forever #2 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Leading edge keeps a released request visible for one cycle
  task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk);
    apb <= {1'b1, 1'b0, w, {2'b0, idx, 2'b0}, wd, strb};
    @(posedge clk);
    apb.penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1 && n < 20);
    if (pready !== 1) begin
      fail_count++;
      summarize();
    end else begin
      r = prdata;
      e = pslverr;
      apb <= '0;
    end
  endtask

  task automatic frame(input int pre, bad, output logic mo);
    int n;
    @(posedge clk);
    sfd <= 1;
    for (int k = 0; k < pre + 16; k++) begin
      @(posedge clk);
      sfd <= 0;
      vld <= 1;
      dat <= k < pre ? 8'($urandom) : plow[k - pre] ^ 8'(k - pre == bad);
      fend <= k == pre + 15;
    end
    @(posedge clk);
    vld <= 0;
    fend <= 0;
    n = 0;
    while (mvalid !== 1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    if (mvalid !== 1) begin
      fail_count++;
      summarize();
    end else begin
      mo = match;
    end
  endtask

  function automatic logic exp_match(int bad, logic [15:0] mk);
    return bad < 0 || mk[bad];
  endfunction

  task automatic reset_check;
    for (int i = 0; i < 12; i++) begin
      xfer(0, 12'h4c1 + 12'(i), 0);
      chk("reset", r, i == 11 ? 32'hc : 0);
    end
  endtask

  initial begin
    void'($urandom(11));
    for (int i = 0; i < 50; i++) plow[i] <= 8'($urandom);
    repeat (3) @(posedge clk);
    rst <= 0;
    reset_check();
    $display("test reset values done");
    for (int i = 0; i < 11; i++) begin
      d = $urandom;
      xfer(1, 12'h4c1 + 12'(i), d);
      xfer(0, 12'h4c1 + 12'(i), 0);
      chk("readback", r, {16'h0, d[15:0]});
      if (i < 7)
        chk("pat", 32'(phigh[2*i+1 -: 2]), 32'(d[15:0]));
      else
        chk("mask", 32'(mask[16*(i-7) +: 16]), 32'(d[15:0]));
    end
    // Low lane only: the odd byte keeps its value
    xfer(0, 12'h4c2, 0);
    d = r;
    strb = 4'h1;
    xfer(1, 12'h4c2, 32'h0000_a55a);
    strb = 4'hf;
    xfer(0, 12'h4c2, 0);
    chk("strobe", r, {16'h0, d[15:8], 8'h5a});
    xfer(0, 12'h4cd, 0);
    chk("err", {31'h0, e}, 1);
    $display("test register access done");
    // Bytes past the 16-byte window are masked off
    for (int i = 9; i < 12; i++) xfer(1, 12'h4c0 + 12'(i), 32'hffff);
    for (int t = 0; t < 4; t++) begin
      b = $urandom % 16;
      mk = t == 2 ? 16'h1 << b : t == 3 ? ~(16'h1 << b) : 16'h0;
      xfer(1, 12'h4c8, {16'h0, mk});
      xfer(1, 12'h4cc, t > 1 ? 3 : 0);
      frame(t > 1 ? 3 : 0, t == 0 ? -1 : b, m);
      chk("match", {31'h0, m}, {31'h0, exp_match(t == 0 ? -1 : b, mk)});
      chk("start", 32'(start), t > 1 ? 3 : 0);
    end
    $display("test pattern match done");
    // Mid-run reset must return everything written so far to its reset value
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    reset_check();
    frame(12, -1, m);
    chk("short frame", {31'h0, m}, 0);
    for (int i = 9; i < 12; i++) xfer(1, 12'h4c0 + 12'(i), 32'hffff);
    frame(12, -1, m);
    chk("default start", {31'h0, m}, 1);
    $display("test mid-run reset done");
    summarize();
  end
endmodule // rxpm_config_regs_test
